// ---- logic/comc_bit_tick.sv ----
// Bit-time enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module comc_bit_tick #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt;
   wire logic wrap = (cnt >= div);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= wrap ? '0 : cnt + 1'b1;
         tick <= wrap;
      end
   end
endmodule
`default_nettype wire

// ---- logic/comc_map.svh ----
// Register offsets, field positions, reset values and counts of the CAN mode controller
`ifndef COMC_MAP_SVH
`define COMC_MAP_SVH

`define COMC_OFF_CTRL1 8'h00
`define COMC_OFF_CFG1 8'h04
`define COMC_OFF_CFG2 8'h08
`define COMC_OFF_STAT 8'h0C
`define COMC_OFF_TXCTL 8'h10
`define COMC_OFF_ERRCNT 8'h14

`define COMC_REQ_HI 10
`define COMC_REQ_LO 8
`define COMC_OPM_HI 7
`define COMC_OPM_LO 5
`define COMC_WAKFILT_BIT 14
`define COMC_TX_REQUEST_FLAG_BIT 3
`define COMC_TX_ABORTED_FLAG_BIT 6
`define COMC_WAKE_BIT 0
`define COMC_IDLE_BIT 1
`define COMC_PEND_BIT 2

`define COMC_MODE_NORMAL 3'h0
`define COMC_MODE_DISABLE 3'h1
`define COMC_MODE_LOOP 3'h2
`define COMC_MODE_LISTEN 3'h3
`define COMC_MODE_INIT 3'h4
`define COMC_MODE_LALL 3'h7

`define COMC_RESET_MODE 3'h4
`define COMC_CFG1_RESET 32'h0000_0009
`define COMC_CFG2_RESET 15'h0000
`define COMC_IDLE_BITS 4'hB
`define COMC_FILT_LEN 8
`define COMC_RESP_OKAY 2'h0
`define COMC_RESP_DECERR 2'h3

`endif

// ---- logic/comc_mode_ctrl.sv ----
// CAN operating mode controller with AXI4-Lite registers
//
// Behaviour
// - Mode in effect reads back at bits 7:5
// - Mode change of an active module waits for eleven recessive idle bits
// - Initialization mode neither transmits nor receives
// - Entering initialization clears error counters, keeps flags
// - Configuration writes ignored outside initialization mode
// - No initialization entry during an ongoing transmission
// - Disable: silent, flags kept, counters held
// - Disable: receive activity sets wake flag
// - Code 001 requests disable after idle bus
// - Report shows 001 only once disabled
// - Disable releases pins to port function
// - Wake filter bit 14 low-passes receive line
// - First transmission waits eleven recessive bits
// - Disable during that wait aborts transmission
// - Code 000 selects normal mode on pins
// - Code 111 listens to all, ignoring errors
// - Listen only: passive, no ack, counters off
// - Loopback joins internal transmit to receive
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "comc_map.svh"
module comc_mode_ctrl
   import comc_pkg::*;
#(
   parameter int AW = 8,
   parameter int FILT_LEN = `COMC_FILT_LEN
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bus_rx_pin,
   output logic bus_tx_pin,
   output logic bus_tx_pin_oe,
   output logic bus_pins_claimed,
   input wire logic cpu_sleep,
   input wire logic core_tx_bit,
   input wire logic core_tx_busy,
   input wire logic core_err_tx,
   input wire logic core_err_rx,
   output logic core_rx_bit,
   output logic core_tx_start,
   output logic core_tx_enable,
   output logic core_rx_enable,
   output logic core_ack_enable,
   output logic core_listen_all
);
   logic [2:0] req_mode;
   logic [2:0] op_mode;
   comc_cfg_type cfg;
   logic wake_flag;
   logic tx_request_flag;
   logic tx_aborted_flag;
   logic [7:0] tec;
   logic [7:0] rec;
   logic [3:0] idle_cnt;
   logic [3:0] wait_cnt;
   comc_tx_state_type tx_state;
   logic rx_meta;
   logic rx_sync;
   logic rx_filt;
   logic rx_prev;
   logic bit_tick;
   logic [AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held;
   logic w_held;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Receive pin synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= bus_rx_pin;
         rx_sync <= rx_meta;
      end
   end

   comc_bit_tick #(.W(8)) u_tick (
      .mclk(mclk),
      .rst_n(rst_n),
      .div(cfg.prescale),
      .tick(bit_tick)
   );

   comc_rx_filter #(.LEN(FILT_LEN)) u_filt (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(rx_sync),
      .dout(rx_filt)
   );

   // Mode decode
   wire logic in_init = (op_mode == `COMC_MODE_INIT);
   wire logic in_dis = (op_mode == `COMC_MODE_DISABLE);
   wire logic in_loop = (op_mode == `COMC_MODE_LOOP);
   wire logic in_listen = (op_mode == `COMC_MODE_LISTEN);
   wire logic in_lall = (op_mode == `COMC_MODE_LALL);
   wire logic active = !in_init && !in_dis;
   wire logic may_tx = (op_mode == `COMC_MODE_NORMAL) || in_loop;
   wire logic req_valid = (req_mode <= `COMC_MODE_INIT) || (req_mode == `COMC_MODE_LALL);
   wire logic pending = (req_mode != op_mode) && req_valid;
   // Inside the module the receive path sees the transmit path in loopback
   wire logic rx_int = in_loop ? core_tx_bit : rx_sync;
   // Filtered line used only for wake detection while asleep or disabled
   wire logic use_filt = cfg.wake_filter_enable && (cpu_sleep || in_dis);
   wire logic rx_wake = use_filt ? rx_filt : rx_sync;
   wire logic wake_edge = rx_prev && !rx_wake;
   wire logic bus_idle = (idle_cnt == `COMC_IDLE_BITS);
   wire logic idle_ok = !active || bus_idle;
   wire logic init_ok = !core_tx_busy && (tx_state != TX_SEND) && (tx_state != TX_START);
   wire logic change_ok = pending && idle_ok && ((req_mode != `COMC_MODE_INIT) || init_ok);
   wire logic [2:0] next_mode = change_ok ? req_mode : op_mode;
   wire logic abort_now = (tx_state == TX_WAIT) && (req_mode == `COMC_MODE_DISABLE);
   wire logic counters_on = !in_dis && !in_listen && !in_init;

   // Bus write and read address decode
   wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire logic [AW-1:0] wa = aw_addr;
   wire logic wr_ctrl = wr_fire && (wa == AW'(`COMC_OFF_CTRL1));
   wire logic wr_cfg1 = wr_fire && (wa == AW'(`COMC_OFF_CFG1)) && in_init;
   wire logic wr_cfg2 = wr_fire && (wa == AW'(`COMC_OFF_CFG2)) && in_init;
   wire logic wr_stat = wr_fire && (wa == AW'(`COMC_OFF_STAT));
   wire logic wr_txc = wr_fire && (wa == AW'(`COMC_OFF_TXCTL));
   wire logic wr_known = (wa == AW'(`COMC_OFF_CTRL1)) || (wa == AW'(`COMC_OFF_CFG1)) ||
      (wa == AW'(`COMC_OFF_CFG2)) || (wa == AW'(`COMC_OFF_STAT)) ||
      (wa == AW'(`COMC_OFF_TXCTL)) || (wa == AW'(`COMC_OFF_ERRCNT));
   wire logic [31:0] wm = merge(32'h0000_0000, w_data, w_strb);
   wire logic [31:0] ctrl_word = {21'h00_0000, req_mode, op_mode, 5'h00};
   wire logic [31:0] cfg1_word = {24'h00_0000, cfg.prescale};
   wire logic [31:0] cfg2_word = {17'h0_0000, cfg.wake_filter_enable, cfg.cfg2_rest};
   wire logic [31:0] stat_word = {29'h0000_0000, pending, bus_idle, wake_flag};
   wire logic [31:0] txc_word = {25'h000_0000, tx_aborted_flag, 2'h0, tx_request_flag, 3'h0};
   wire logic [31:0] err_word = {16'h0000, rec, tec};
   wire logic [AW-1:0] ra = s_axi_araddr;
   wire logic rd_known = (ra == AW'(`COMC_OFF_CTRL1)) || (ra == AW'(`COMC_OFF_CFG1)) ||
      (ra == AW'(`COMC_OFF_CFG2)) || (ra == AW'(`COMC_OFF_STAT)) ||
      (ra == AW'(`COMC_OFF_TXCTL)) || (ra == AW'(`COMC_OFF_ERRCNT));
   wire logic [31:0] rd_word =
      (ra == AW'(`COMC_OFF_CTRL1)) ? ctrl_word :
      (ra == AW'(`COMC_OFF_CFG1)) ? cfg1_word :
      (ra == AW'(`COMC_OFF_CFG2)) ? cfg2_word :
      (ra == AW'(`COMC_OFF_STAT)) ? stat_word :
      (ra == AW'(`COMC_OFF_TXCTL)) ? txc_word :
      (ra == AW'(`COMC_OFF_ERRCNT)) ? err_word : 32'h0000_0000;
   wire logic [31:0] new_ctrl = merge(ctrl_word, w_data, w_strb);
   wire logic [31:0] new_cfg1 = merge(cfg1_word, w_data, w_strb);
   wire logic [31:0] new_cfg2 = merge(cfg2_word, w_data, w_strb);

   // Write channel capture, in either order
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `COMC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `COMC_RESP_OKAY : `COMC_RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   // Read channel
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `COMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_known ? `COMC_RESP_OKAY : `COMC_RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   // Mode request, reported mode and locked configuration
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_mode <= `COMC_RESET_MODE;
         op_mode <= `COMC_RESET_MODE;
         cfg.prescale <= 8'(`COMC_CFG1_RESET);
         cfg.wake_filter_enable <= 1'b0;
         cfg.cfg2_rest <= 14'(`COMC_CFG2_RESET);
      end else begin
         if (wr_ctrl) begin
            req_mode <= new_ctrl[`COMC_REQ_HI:`COMC_REQ_LO];
         end
         op_mode <= next_mode;
         if (wr_cfg1) begin
            cfg.prescale <= new_cfg1[7:0];
         end
         if (wr_cfg2) begin
            cfg.wake_filter_enable <= new_cfg2[`COMC_WAKFILT_BIT];
            cfg.cfg2_rest <= new_cfg2[13:0];
         end
      end
   end

   // Idle counter of recessive bits and wake flag
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt <= 4'h0;
         rx_prev <= 1'b1;
         wake_flag <= 1'b0;
      end else begin
         rx_prev <= rx_wake;
         if (bit_tick) begin
            if (!rx_int) begin
               idle_cnt <= 4'h0;
            end else if (!bus_idle) begin
               idle_cnt <= idle_cnt + 4'h1;
            end
         end
         if (in_dis && wake_edge) begin
            wake_flag <= 1'b1;
         end else if (wr_stat && wm[`COMC_WAKE_BIT]) begin
            wake_flag <= 1'b0;
         end
      end
   end

   // Error counters
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tec <= 8'h00;
         rec <= 8'h00;
      end else if (next_mode == `COMC_MODE_INIT && !in_init) begin
         tec <= 8'h00;
         rec <= 8'h00;
      end else if (counters_on && !in_lall) begin
         if (core_err_tx && tec != 8'hFF) begin
            tec <= tec + 8'h01;
         end
         if (core_err_rx && rec != 8'hFF) begin
            rec <= rec + 8'h01;
         end
      end
   end

   // Transmit request sequencing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         wait_cnt <= 4'h0;
         tx_request_flag <= 1'b0;
         tx_aborted_flag <= 1'b0;
         core_tx_start <= 1'b0;
      end else begin
         core_tx_start <= 1'b0;
         if (wr_txc) begin
            tx_request_flag <= wm[`COMC_TX_REQUEST_FLAG_BIT];
            if (wm[`COMC_TX_ABORTED_FLAG_BIT]) begin
               tx_aborted_flag <= 1'b0;
            end
         end
         unique case (tx_state)
            TX_IDLE: begin
               wait_cnt <= 4'h0;
               if (tx_request_flag && may_tx && !pending) begin
                  tx_state <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (abort_now) begin
                  tx_state <= TX_IDLE;
                  tx_aborted_flag <= 1'b1;
                  tx_request_flag <= 1'b0;
               end else if (!may_tx || !tx_request_flag) begin
                  tx_state <= TX_IDLE;
               end else if (wait_cnt == `COMC_IDLE_BITS) begin
                  tx_state <= TX_START;
                  core_tx_start <= 1'b1;
               end else if (bit_tick) begin
                  wait_cnt <= rx_int ? wait_cnt + 4'h1 : 4'h0;
               end
            end
            TX_START: begin
               if (core_tx_busy) begin
                  tx_state <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (!core_tx_busy) begin
                  tx_state <= TX_IDLE;
                  tx_request_flag <= 1'b0;
               end
            end
         endcase
      end
   end

   // Pin and protocol engine controls
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_tx_pin <= 1'b1;
         bus_tx_pin_oe <= 1'b0;
         bus_pins_claimed <= 1'b0;
         core_rx_bit <= 1'b1;
         core_tx_enable <= 1'b0;
         core_rx_enable <= 1'b0;
         core_ack_enable <= 1'b0;
         core_listen_all <= 1'b0;
      end else begin
         bus_tx_pin <= (op_mode == `COMC_MODE_NORMAL) ? core_tx_bit : 1'b1;
         bus_tx_pin_oe <= (op_mode == `COMC_MODE_NORMAL) || in_lall;
         bus_pins_claimed <= !in_dis && !in_loop;
         core_rx_bit <= rx_int;
         core_tx_enable <= may_tx;
         core_rx_enable <= active;
         core_ack_enable <= (op_mode == `COMC_MODE_NORMAL) || in_loop;
         core_listen_all <= in_lall;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence disable_wait_s;
      tx_state == TX_WAIT && req_mode == `COMC_MODE_DISABLE;
   endsequence
   sequence aborted_s;
      tx_aborted_flag && !tx_request_flag && tx_state == TX_IDLE;
   endsequence

   mode_follows_req_a: assert property ($changed(op_mode) |-> op_mode == $past(req_mode))
      else $error("reported mode changed to a value not requested");
   active_change_idle_a: assert property ($changed(op_mode) && $past(active) |-> $past(bus_idle))
      else $error("active module changed mode without idle bus");
   init_silent_a: assert property (in_init && $past(in_init) |-> !core_tx_enable && !core_rx_enable)
      else $error("engine enabled in initialization mode");
   init_clears_err_a: assert property ($rose(in_init) |-> tec == 8'h00 && rec == 8'h00)
      else $error("error counters not cleared on initialization entry");
   cfg_locked_a: assert property ($changed(cfg) |-> $past(in_init))
      else $error("configuration changed outside initialization mode");
   init_no_tx_a: assert property ($rose(in_init) |-> !$past(core_tx_busy))
      else $error("initialization entered during transmission");
   disable_hold_a: assert property (in_dis && $past(in_dis) |-> $stable(tec) && $stable(rec))
      else $error("error counters moved in disable mode");
   wake_set_a: assert property (in_dis && wake_edge |=> wake_flag)
      else $error("wake flag not set on bus activity");
   pins_release_a: assert property (in_dis ##1 in_dis |-> !bus_tx_pin_oe && !bus_pins_claimed)
      else $error("pins still claimed in disable mode");
   abort_tx_a: assert property (disable_wait_s |=> aborted_s)
      else $error("pending transmission not aborted on disable request");
   start_after_idle_a: assert property (core_tx_start |-> $past(wait_cnt) == `COMC_IDLE_BITS)
      else $error("transmission started before eleven recessive bits");
endmodule
`default_nettype wire

// ---- logic/comc_pkg.sv ----
// Types shared by the CAN mode controller
package comc_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_SEND} comc_tx_state_type;
   typedef struct packed {
      logic [7:0] prescale;
      logic wake_filter_enable;
      logic [13:0] cfg2_rest;
   } comc_cfg_type;
endpackage

// ---- logic/comc_rx_filter.sv ----
// Low-pass filter for the receive line: a level must hold LEN cycles to pass
`timescale 1ns/1ps
`default_nettype none
module comc_rx_filter #(
   parameter int LEN = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic [$clog2(LEN+1)-1:0] run;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run <= '0;
         dout <= 1'b1;
      end else if (din == dout) begin
         run <= '0;
      end else if (run == ($clog2(LEN+1))'(LEN - 1)) begin
         run <= '0;
         dout <= din;
      end else begin
         run <= run + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/can_operating_mode_control_tb_top.sv ----
// Self-checking bench for the CAN mode controller
`timescale 1ns/1ps
`default_nettype none
module can_operating_mode_control_tb_top;
   import comc_pkg::*;
   logic mclk, rst_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic bus_rx_pin, bus_tx_pin, bus_tx_pin_oe, bus_pins_claimed, cpu_sleep, node_dom;
   logic core_tx_bit, core_tx_busy, core_err_tx, core_err_rx, core_rx_bit, core_tx_start;
   logic core_tx_enable, core_rx_enable, core_ack_enable, core_listen_all;
   int fails, samples_checked, m_req, m_mode, m_tec, m_rec, n;
   logic qb[$];

   comc_mode_ctrl #(.FILT_LEN(8)) dut_u (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .bus_rx_pin, .bus_tx_pin, .bus_tx_pin_oe, .bus_pins_claimed, .cpu_sleep,
      .core_tx_bit, .core_tx_busy, .core_err_tx, .core_err_rx, .core_rx_bit, .core_tx_start,
      .core_tx_enable, .core_rx_enable, .core_ack_enable, .core_listen_all);
   comc_bus_node node_u (.bus_tx_pin, .bus_tx_pin_oe, .bus_pins_claimed, .node_dom, .bus_rx_pin);

   initial begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic conclude();
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic guard(input int k);
      if (k > 300) begin
         fails++;
         conclude();
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      int k;
      k = 0;
      b = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!b) begin
         @(negedge mclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge mclk);
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
         k++;
         guard(k);
      end
   endtask

   task automatic axr(input logic [7:0] a);
      logic ar, r;
      int k;
      k = 0;
      r = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      while (!r) begin
         @(negedge mclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge mclk);
         if (ar) s_axi_arvalid <= 0;
         k++;
         guard(k);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input string nm, input logic [31:0] exp);
      axr(a);
      chk(nm, rd, exp);
   endtask

   // Pin and engine enables expected per mode: oe, tx, rx, listen-all
   function automatic logic [31:0] exp_outs(input int m);
      case (m)
         0: return 32'h0000_000E;
         2: return 32'h0000_0006;
         3: return 32'h0000_0002;
         7: return 32'h0000_000B;
         default: return 32'h0000_0000;
      endcase
   endfunction

   task automatic go(input int m);
      int k;
      k = 0;
      m_req = m;
      axw(8'h00, 32'(m) << 8);
      axr(8'h00);
      while (rd[7:5] !== 3'(m)) begin
         axr(8'h00);
         k++;
         guard(k);
      end
      m_mode = m;
      if (m == 4) begin
         m_tec = 0;
         m_rec = 0;
      end
      chk("ctrl", rd, 32'((m_req << 8) | (m_mode << 5)));
      chk("outs", {bus_tx_pin_oe, core_tx_enable, core_rx_enable, core_listen_all}, exp_outs(m));
   endtask

   task automatic errs(input int t, input int r);
      for (int i = 0; i < 6; i++) begin
         core_err_tx <= (i % 2 == 0) && (i / 2 < t);
         core_err_rx <= (i % 2 == 0) && (i / 2 < r);
         @(posedge mclk);
      end
      if (m_mode == 0 || m_mode == 2) begin
         m_tec += t;
         m_rec += r;
      end
   endtask

   task automatic dom(input int k);
      node_dom <= 1;
      tick(k);
      node_dom <= 0;
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      conclude();
   end

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {cpu_sleep, node_dom, core_tx_bit, core_tx_busy, core_err_tx, core_err_rx} = '0;
      core_tx_bit = 1;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1;
      s_axi_rready = 1;
      rst_n = 0;
      fails = 0;
      samples_checked = 0;
      m_req = 4;
      m_mode = 4;
      m_tec = 0;
      m_rec = 0;
      void'($urandom(32'ha19f_d7a4));
      tick(20);
      rst_n <= 1;
      tick(1);
      rdchk(8'h00, "ctrl", 32'h0000_0480);
      rdchk(8'h04, "cfg1", 32'h0000_0009);
      rdchk(8'h40, "unmapped", 32'h0000_0000);
      chk("resp", rr, 32'h0000_0003);
      axw(8'h04, 32'h0000_0000);
      n = $urandom_range(16383);
      axw(8'h08, n);
      rdchk(8'h08, "cfg2", n);
      go(0);
      chk("claimed", bus_pins_claimed, 1);
      axw(8'h04, 32'h0000_0005);
      rdchk(8'h04, "cfg1", 32'h0000_0000);
      errs(3, 2);
      rdchk(8'h14, "errcnt", 32'((m_rec << 8) | m_tec));
      axw(8'h10, 32'h0000_0008);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
         guard(n);
      end while (core_tx_start !== 1'b1);
      chk("idle_wait", n >= 10, 1);
      @(posedge mclk);
      core_tx_busy <= 1;
      axw(8'h00, 32'h0000_0400);
      m_req = 4;
      tick(30);
      rdchk(8'h00, "ctrl", 32'h0000_0400);
      core_tx_busy <= 0;
      go(4);
      rdchk(8'h14, "errcnt", 32'h0000_0000);
      go(0);
      node_dom <= 1;
      tick(4);
      axw(8'h00, 32'h0000_0700);
      tick(30);
      rdchk(8'h00, "ctrl", 32'h0000_0700);
      rdchk(8'h0C, "stat", 32'h0000_0004);
      node_dom <= 0;
      go(7);
      go(3);
      chk("ack", core_ack_enable, 0);
      go(2);
      chk("claimed", bus_pins_claimed, 0);
      for (int i = 0; i < 16; i++) begin
         qb.push_back(1'($urandom_range(1)));
         core_tx_bit <= qb[$];
         @(posedge mclk);
         @(negedge mclk);
         chk("loop_rx", core_rx_bit, qb.pop_front());
         @(posedge mclk);
      end
      core_tx_bit <= 1;
      go(0);
      errs(1, 0);
      node_dom <= 1;
      axw(8'h10, 32'h0000_0008);
      tick(4);
      axw(8'h00, 32'h0000_0100);
      m_req = 1;
      rdchk(8'h10, "txctl", 32'h0000_0040);
      rdchk(8'h00, "ctrl", 32'h0000_0100);
      node_dom <= 0;
      go(1);
      chk("claimed", bus_pins_claimed, 0);
      errs(2, 2);
      rdchk(8'h14, "errcnt", 32'((m_rec << 8) | m_tec));
      dom(20);
      axr(8'h0C);
      chk("wake", rd[0], 1);
      axw(8'h0C, 32'h0000_0001);
      axr(8'h0C);
      chk("wake", rd[0], 0);
      go(4);
      axw(8'h08, 32'h0000_4000);
      go(1);
      cpu_sleep <= 1;
      axw(8'h0C, 32'h0000_0001);
      dom(3);
      tick(12);
      axr(8'h0C);
      chk("wake", rd[0], 0);
      dom(20);
      axr(8'h0C);
      chk("wake", rd[0], 1);
      conclude();
   end
endmodule
`default_nettype wire

// ---- testbench/comc_bus_node.sv ----
// Far CAN node and transceiver: wired-AND bus level seen at the receive pin
`timescale 1ns/1ps
`default_nettype none
module comc_bus_node (
   input wire logic bus_tx_pin,
   input wire logic bus_tx_pin_oe,
   input wire logic bus_pins_claimed,
   input wire logic node_dom,
   output logic bus_rx_pin
);
   wire logic dev_drives;
   // Released pin floats to recessive through the pull-up
   assign dev_drives = bus_tx_pin_oe && bus_pins_claimed;
   assign bus_rx_pin = !node_dom && (!dev_drives || bus_tx_pin);
endmodule
`default_nettype wire
